// [ppd_pkg.sv]
// shared constants and types for the point-plot display control
`default_nettype none

package ppd_pkg;

  // clock period of clk_in
  localparam int CLK_PERIOD_NS = 20;

  // device code seen on instruction bits 3..8 (octal 05)
  localparam logic [5:0] DEV_CODE = 6'h05;

  // operation codes on instruction bits 9..11
  localparam logic [2:0] OPC_SKIP_DONE = 3'h1;
  localparam logic [2:0] OPC_CLEAR_DONE = 3'h2;
  localparam logic [2:0] OPC_LOAD_X = 3'h3;
  localparam logic [2:0] OPC_LOAD_Y = 3'h4;
  localparam logic [2:0] OPC_INTENSIFY = 3'h5;
  localparam logic [2:0] OPC_LOAD_ENABLE = 3'h6;
  localparam logic [2:0] OPC_READ_ENABLE = 3'h7;

  // bit positions on the data bus, bit 0 is the most significant
  localparam int BIT_DONE = 0;
  localparam int BIT_WRITE_THRU = 6;
  localparam int BIT_STORE = 7;
  localparam int BIT_ERASE = 8;
  localparam int BIT_RED = 9;
  localparam int BIT_CHAN = 10;
  localparam int BIT_INT_EN = 11;
  localparam int AXIS_FIRST = 2;
  localparam int AXIS_LAST = 11;
  localparam int AXIS_W = 10;

  // settle and intensify times
  localparam int SETTLE_RASTER_NS = 21000;
  localparam int SETTLE_RASTER_RED_NS = 16000;
  localparam int SETTLE_STORAGE_NS = 100000;
  localparam int SETTLE_FAST_NS = 6000;
  localparam int INTENS_GREEN_NS = 6000;
  localparam int INTENS_RED_NS = 2000;

  // least times round up to whole cycles
  localparam int CNT_W = 13;
  localparam int SETTLE_RASTER_CYC = (SETTLE_RASTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_RASTER_RED_CYC = (SETTLE_RASTER_RED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_STORAGE_CYC = (SETTLE_STORAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_FAST_CYC = (SETTLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTENS_GREEN_CYC = (INTENS_GREEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTENS_RED_CYC = (INTENS_RED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bus word, indexed in the processor's bit order
  typedef logic [0:11] ppd_word_t;

  // decoded operation
  typedef enum logic [2:0] {
    PPD_OP_NONE,
    PPD_OP_SKIP_DONE,
    PPD_OP_CLEAR_DONE,
    PPD_OP_LOAD_X,
    PPD_OP_LOAD_Y,
    PPD_OP_INTENSIFY,
    PPD_OP_LOAD_ENABLE,
    PPD_OP_READ_ENABLE
  } ppd_op_t;

  // stored mode bits of the enable/status register
  typedef struct packed {
    logic int_enable;
    logic chan2;
    logic red;
    logic erase;
    logic store;
    logic write_through;
  } ppd_mode_t;

  // what the block puts on the data bus
  typedef struct packed {
    ppd_word_t data;
    ppd_word_t oe_n;
  } ppd_bus_drive_t;

  localparam ppd_mode_t MODE_RESET = '0;

endpackage : ppd_pkg

`default_nettype wire

// [ppd_oneshot.sv]
// clocked one-shot used for the settle delay and the intensify pulse
`timescale 1ns/1ps
`default_nettype none

module ppd_oneshot (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [ppd_pkg::CNT_W-1:0] length_in,
  output logic active_out,
  output logic expire_out
);

  logic [ppd_pkg::CNT_W-1:0] count;
  logic last;

  // a new start retriggers, so a later load always gets its full time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (start_in) begin
      count <= length_in;
    end else if (count != '0) begin
      count <= count - ppd_pkg::CNT_W'(1);
    end
  end

  // one-cycle pulse in the cycle after the count runs out
  assign last = (count == ppd_pkg::CNT_W'(1)) && !start_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      expire_out <= 1'b0;
    end else begin
      expire_out <= last;
    end
  end

  assign active_out = (count != '0);

endmodule : ppd_oneshot

`default_nettype wire

// [ppd_control.sv]
// point-plot display control: instruction decode, holding registers, enable/status, timing
// What this block does
// - device code recognised, then low three bits decode one of eight; 011 loads X
// - load X and load Y leave both direction control lines unasserted
// - load enable asserts control zero, captures data, accumulator gets cleared
// - read enable asserts both control lines to jam status into accumulator
// - system init or console clear clears done
// - clear-done and intensify instructions clear done
// - colour change or erase start clears done
// - loads clear done; done sets only when settle delay fires after load and pulse three
// - settle is 21us raster, 16us raster red, 100us storage, 6us fast scope
// - switch picks long or short delay, jumper picks raster or storage set
// - done with interrupt enable requests a program interrupt
// - skip-on-done with done set requests a skip
// - read enable drives done onto data bit 0, low when done
// - interrupt enable cleared by console clear, loaded from bit 11, readable back
// - load enable takes channel from bit 10, low means channel 2
// - read enable returns channel on bit 10, low for channel 2
// - intensify instruction with pulse three emits one intensify pulse
// - intensify pulse lasts 6us green non-store, 2us red non-store
// - a switch fixes intensify polarity
// - load X or Y captures bus bits 02 to 11 into the holding register
// - holding registers drive converters continuously until reloaded
// - enable bits: 6 write-through, 7 store, 8 erase, 9 red
// - load X, load Y, intensify use codes 6053, 6054, 6055
`timescale 1ns/1ps
`default_nettype none

module ppd_control #(
  parameter int SETTLE_STORAGE_CYCLES = ppd_pkg::SETTLE_STORAGE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [0:8] instruction_bits_in,
  input wire logic io_pause_in,
  input wire logic timing_pulse_three_in,
  input wire logic system_init_in,
  input wire logic console_clear_in,
  input wire ppd_pkg::ppd_word_t data_in,
  input wire logic pulse_polarity_switch_in,
  input wire logic delay_length_switch_in,
  input wire logic storage_jumper_in,
  output ppd_pkg::ppd_bus_drive_t data_drive_out,
  output logic bus_dir_ctl_zero_n_out,
  output logic bus_dir_ctl_one_n_out,
  output logic skip_req_out,
  output logic interrupt_req_out,
  output logic intensify_out,
  output logic [ppd_pkg::AXIS_W-1:0] x_axis_out,
  output logic [ppd_pkg::AXIS_W-1:0] y_axis_out,
  output ppd_pkg::ppd_mode_t mode_out
);

  // decode of the operation field once the device code matches
  function automatic ppd_pkg::ppd_op_t decode_op(input logic [0:8] instr);
    ppd_pkg::ppd_op_t op;
    op = ppd_pkg::PPD_OP_NONE;
    // other devices share the bus; a foreign code decodes to nothing
    if (instr[0:5] == ppd_pkg::DEV_CODE) begin
      case (instr[6:8])
        ppd_pkg::OPC_SKIP_DONE: begin
          op = ppd_pkg::PPD_OP_SKIP_DONE;
        end
        ppd_pkg::OPC_CLEAR_DONE: begin
          op = ppd_pkg::PPD_OP_CLEAR_DONE;
        end
        ppd_pkg::OPC_LOAD_X: begin
          op = ppd_pkg::PPD_OP_LOAD_X;
        end
        ppd_pkg::OPC_LOAD_Y: begin
          op = ppd_pkg::PPD_OP_LOAD_Y;
        end
        ppd_pkg::OPC_INTENSIFY: begin
          op = ppd_pkg::PPD_OP_INTENSIFY;
        end
        ppd_pkg::OPC_LOAD_ENABLE: begin
          op = ppd_pkg::PPD_OP_LOAD_ENABLE;
        end
        ppd_pkg::OPC_READ_ENABLE: begin
          op = ppd_pkg::PPD_OP_READ_ENABLE;
        end
        default: begin
          op = ppd_pkg::PPD_OP_NONE;
        end
      endcase
    end
    return op;
  endfunction : decode_op

  // cycles as counter width, from an int figure
  // counts above the counter width would wrap; keep the parameter small
  function automatic logic [ppd_pkg::CNT_W-1:0] to_cnt(input int cyc);
    return ppd_pkg::CNT_W'(cyc);
  endfunction : to_cnt

  // reset and pin synchronisers
  logic rst_meta;
  logic rst_n;
  logic [1:0] pol_sync;
  logic [1:0] len_sync;
  logic [1:0] jmp_sync;
  logic polarity_neg;
  logic delay_long;
  logic storage_set;

  // decode and strobes
  ppd_pkg::ppd_op_t op;
  logic active;
  logic strobe;
  logic load_x_strobe;
  logic load_y_strobe;
  logic load_en_strobe;
  logic intens_strobe;
  logic clr_done_strobe;
  logic reading;

  // enable/status state
  ppd_pkg::ppd_mode_t mode;
  ppd_pkg::ppd_mode_t next_mode;
  logic done;
  logic done_clear;
  logic mode_clears_done;

  // timers
  logic [ppd_pkg::CNT_W-1:0] settle_len;
  logic [ppd_pkg::CNT_W-1:0] intens_len;
  logic settle_fire;
  logic intens_active;

  // axes and bus drive
  logic [ppd_pkg::AXIS_W-1:0] x_hold;
  logic [ppd_pkg::AXIS_W-1:0] y_hold;
  ppd_pkg::ppd_bus_drive_t drive;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // switches and jumper are pins, so two flops before use
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pol_sync <= 2'h0;
      len_sync <= 2'h0;
      jmp_sync <= 2'h0;
    end else begin
      pol_sync <= {pol_sync[0], pulse_polarity_switch_in};
      len_sync <= {len_sync[0], delay_length_switch_in};
      jmp_sync <= {jmp_sync[0], storage_jumper_in};
    end
  end

  // synchronised copies of the pins
  assign polarity_neg = pol_sync[1];
  assign delay_long = len_sync[1];
  assign storage_set = jmp_sync[1];

  // instruction decode, gated by the pause strobe so only transfers count
  assign op = decode_op(instruction_bits_in);
  assign active = io_pause_in
    && (op != ppd_pkg::PPD_OP_NONE);
  assign strobe = active && timing_pulse_three_in;
  assign load_x_strobe = strobe && (op == ppd_pkg::PPD_OP_LOAD_X);
  assign load_y_strobe = strobe && (op == ppd_pkg::PPD_OP_LOAD_Y);
  assign load_en_strobe = strobe && (op == ppd_pkg::PPD_OP_LOAD_ENABLE);
  assign intens_strobe = strobe && (op == ppd_pkg::PPD_OP_INTENSIFY);
  assign clr_done_strobe = strobe && (op == ppd_pkg::PPD_OP_CLEAR_DONE);
  // reads need no pulse three, only the pause
  assign reading = active && (op == ppd_pkg::PPD_OP_READ_ENABLE);

  // direction lines, low when asserted; loads leave both high
  always_comb begin
    bus_dir_ctl_zero_n_out = 1'b1;
    bus_dir_ctl_one_n_out = 1'b1;
    if (active && op == ppd_pkg::PPD_OP_LOAD_ENABLE) begin
      // control zero alone makes the processor clear its accumulator
      bus_dir_ctl_zero_n_out = 1'b0;
    end else if (reading) begin
      // both lines jam the status word in
      bus_dir_ctl_zero_n_out = 1'b0;
      bus_dir_ctl_one_n_out = 1'b0;
    end
  end

  // next mode word from the data bus; bus is low-true except interrupt enable
  always_comb begin
    next_mode = mode;
    if (load_en_strobe) begin
      next_mode.int_enable = data_in[ppd_pkg::BIT_INT_EN];
      next_mode.chan2 = !data_in[ppd_pkg::BIT_CHAN];
      next_mode.red = !data_in[ppd_pkg::BIT_RED];
      next_mode.erase = !data_in[ppd_pkg::BIT_ERASE];
      next_mode.store = !data_in[ppd_pkg::BIT_STORE];
      next_mode.write_through = !data_in[ppd_pkg::BIT_WRITE_THRU];
    end
    // applied last, so console clear beats a load
    if (console_clear_in) begin
      next_mode.int_enable = 1'b0;
    end
  end

  // enable register; console clear beats a load of interrupt enable in the same cycle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ppd_pkg::MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // a colour change or erase start means the old point is stale
  assign mode_clears_done = load_en_strobe
    && ((next_mode.red != mode.red) || next_mode.erase);

  // every source that knocks the done flag down
  // init and clear are levels: held high, done stays low except in the cycle after a settle end fires
  assign done_clear = system_init_in || console_clear_in
    || clr_done_strobe || intens_strobe
    || mode_clears_done
    || load_x_strobe || load_y_strobe;

  // set wins over clear so a settle end is never lost
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (settle_fire) begin
      done <= 1'b1;
    end else if (done_clear) begin
      done <= 1'b0;
    end
  end

  // settle length from switch, jumper and colour
  // short switch overrides the jumper
  always_comb begin
    if (!delay_long) begin
      settle_len = to_cnt(ppd_pkg::SETTLE_FAST_CYC);
    end else if (storage_set) begin
      settle_len = to_cnt(SETTLE_STORAGE_CYCLES);
    end else if (mode.red) begin
      settle_len = to_cnt(ppd_pkg::SETTLE_RASTER_RED_CYC);
    end else begin
      settle_len = to_cnt(ppd_pkg::SETTLE_RASTER_CYC);
    end
  end

  // settle timer, launched by a load with pulse three
  // expire is registered, so done lands one edge after the count
  ppd_oneshot u_settle (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(load_x_strobe || load_y_strobe),
    .length_in(settle_len),
    .active_out(),
    .expire_out(settle_fire)
  );

  // short pulse only for red non-store; store mode uses the long width
  always_comb begin
    if (mode.red && !mode.store) begin
      intens_len = to_cnt(ppd_pkg::INTENS_RED_CYC);
    end else begin
      intens_len = to_cnt(ppd_pkg::INTENS_GREEN_CYC);
    end
  end

  // intensify one-shot, one pulse per instruction
  // a second intensify restarts the pulse
  ppd_oneshot u_intens (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(intens_strobe),
    .length_in(intens_len),
    .active_out(intens_active),
    .expire_out()
  );

  // polarity only flips the level; amplitude is analog and not here
  assign intensify_out = intens_active ^ polarity_neg;

  // holding registers keep their value until the next load of that axis
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      x_hold <= '0;
    end else if (load_x_strobe) begin
      x_hold <= data_in[ppd_pkg::AXIS_FIRST:ppd_pkg::AXIS_LAST];
    end
  end

  // y axis, same as x
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      y_hold <= '0;
    end else if (load_y_strobe) begin
      y_hold <= data_in[ppd_pkg::AXIS_FIRST:ppd_pkg::AXIS_LAST];
    end
  end

  // converters see the registers directly, no gating
  assign x_axis_out = x_hold;
  assign y_axis_out = y_hold;
  assign mode_out = mode;

  // interrupt is a level while done and enable both stand
  assign interrupt_req_out = done && mode.int_enable;

  // skip asked during the skip instruction only
  assign skip_req_out = active && (op == ppd_pkg::PPD_OP_SKIP_DONE)
    && done;

  // read-back word: low on the bus means a one, except interrupt enable
  // bits 1 to 5 and erase stay undriven
  always_comb begin
    drive.data = '1;
    drive.oe_n = '1;
    if (reading) begin
      drive.data[ppd_pkg::BIT_DONE] = !done;
      drive.oe_n[ppd_pkg::BIT_DONE] = 1'b0;
      drive.data[ppd_pkg::BIT_WRITE_THRU] = !mode.write_through;
      drive.oe_n[ppd_pkg::BIT_WRITE_THRU] = 1'b0;
      drive.data[ppd_pkg::BIT_STORE] = !mode.store;
      drive.oe_n[ppd_pkg::BIT_STORE] = 1'b0;
      drive.data[ppd_pkg::BIT_RED] = !mode.red;
      drive.oe_n[ppd_pkg::BIT_RED] = 1'b0;
      drive.data[ppd_pkg::BIT_CHAN] = !mode.chan2;
      drive.oe_n[ppd_pkg::BIT_CHAN] = 1'b0;
      drive.data[ppd_pkg::BIT_INT_EN] = mode.int_enable;
      drive.oe_n[ppd_pkg::BIT_INT_EN] = 1'b0;
    end
  end

  // one carrier for data and enables
  assign data_drive_out = drive;

endmodule : ppd_control

`default_nettype wire

// [ppd_control_properties.sv]
// port-level checks for the point-plot display control
`timescale 1ns/1ps
`default_nettype none

module ppd_control_properties #(
  parameter int SETTLE_STORAGE_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [0:8] instruction_bits_in,
  input wire logic io_pause_in,
  input wire logic timing_pulse_three_in,
  input wire logic system_init_in,
  input wire logic console_clear_in,
  input wire ppd_pkg::ppd_word_t data_in,
  input wire logic pulse_polarity_switch_in,
  input wire logic delay_length_switch_in,
  input wire logic storage_jumper_in,
  input wire ppd_pkg::ppd_bus_drive_t data_drive_out,
  input wire logic bus_dir_ctl_zero_n_out,
  input wire logic bus_dir_ctl_one_n_out,
  input wire logic skip_req_out,
  input wire logic interrupt_req_out,
  input wire logic intensify_out,
  input wire logic [ppd_pkg::AXIS_W-1:0] x_axis_out,
  input wire logic [ppd_pkg::AXIS_W-1:0] y_axis_out,
  input wire ppd_pkg::ppd_mode_t mode_out
);
  logic sel;
  logic [2:0] op;
  logic stb;
  // decode as the bus presents it, strobe needs pulse three
  assign sel = io_pause_in && (instruction_bits_in[0:5] == ppd_pkg::DEV_CODE);
  assign op = instruction_bits_in[6:8];
  assign stb = sel && timing_pulse_three_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  dir_load_a: assert property (
    sel && (op == ppd_pkg::OPC_LOAD_X || op == ppd_pkg::OPC_LOAD_Y) |-> bus_dir_ctl_zero_n_out && bus_dir_ctl_one_n_out)
    else $error("direction line asserted on axis load");
  dir_enable_a: assert property (
    sel && op == ppd_pkg::OPC_LOAD_ENABLE |-> !bus_dir_ctl_zero_n_out && bus_dir_ctl_one_n_out)
    else $error("wrong direction lines on enable load");
  read_status_a: assert property (
    sel && op == ppd_pkg::OPC_READ_ENABLE |-> !bus_dir_ctl_zero_n_out && !bus_dir_ctl_one_n_out
      && !data_drive_out.oe_n[0] && data_drive_out.data[10] == !mode_out.chan2
      && data_drive_out.data[11] == mode_out.int_enable
      && (!mode_out.int_enable || data_drive_out.data[0] == !interrupt_req_out))
    else $error("status read word wrong");
  bus_quiet_a: assert property (
    !(sel && op == ppd_pkg::OPC_READ_ENABLE) |-> data_drive_out.oe_n == '1)
    else $error("bus driven outside status read");
  skip_only_a: assert property (
    !(sel && op == ppd_pkg::OPC_SKIP_DONE) |-> !skip_req_out)
    else $error("skip outside skip instruction");
  x_load_a: assert property (
    stb && op == ppd_pkg::OPC_LOAD_X |=> x_axis_out == $past(data_in[2:11]))
    else $error("x holding value wrong");
  y_hold_a: assert property (
    !(stb && op == ppd_pkg::OPC_LOAD_Y) |=> $stable(y_axis_out))
    else $error("y holding changed without load");
  settle_wait_a: assert property (
    stb && (op == ppd_pkg::OPC_LOAD_X || op == ppd_pkg::OPC_LOAD_Y) |=> !interrupt_req_out [*8])
    else $error("done set before settle");
  done_clear_a: assert property (
    stb && (op == ppd_pkg::OPC_CLEAR_DONE || op == ppd_pkg::OPC_INTENSIFY) |=> !interrupt_req_out)
    else $error("done not cleared");
  mode_load_a: assert property (
    stb && op == ppd_pkg::OPC_LOAD_ENABLE && !console_clear_in |=> mode_out.int_enable == $past(data_in[11])
      && mode_out.chan2 == !$past(data_in[10]) && mode_out.red == !$past(data_in[9]))
    else $error("mode load wrong");
  reset_clear_a: assert property (
    console_clear_in |=> !interrupt_req_out && !mode_out.int_enable)
    else $error("console clear missed");
  init_clear_a: assert property (
    system_init_in |=> !interrupt_req_out)
    else $error("init did not clear done");
  irq_gate_a: assert property (
    interrupt_req_out |-> mode_out.int_enable)
    else $error("interrupt without enable");
  intens_start_a: assert property (
    stb && op == ppd_pkg::OPC_INTENSIFY && !intensify_out && !pulse_polarity_switch_in
      && $stable(pulse_polarity_switch_in) |=> ##[0:2] intensify_out)
    else $error("intensify pulse missing");
endmodule : ppd_control_properties

bind ppd_control ppd_control_properties #(.SETTLE_STORAGE_CYCLES(SETTLE_STORAGE_CYCLES)) chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .instruction_bits_in(instruction_bits_in), .io_pause_in(io_pause_in),
  .timing_pulse_three_in(timing_pulse_three_in), .system_init_in(system_init_in),
  .console_clear_in(console_clear_in), .data_in(data_in), .pulse_polarity_switch_in(pulse_polarity_switch_in),
  .delay_length_switch_in(delay_length_switch_in), .storage_jumper_in(storage_jumper_in),
  .data_drive_out(data_drive_out), .bus_dir_ctl_zero_n_out(bus_dir_ctl_zero_n_out),
  .bus_dir_ctl_one_n_out(bus_dir_ctl_one_n_out), .skip_req_out(skip_req_out),
  .interrupt_req_out(interrupt_req_out), .intensify_out(intensify_out), .x_axis_out(x_axis_out),
  .y_axis_out(y_axis_out), .mode_out(mode_out));

`default_nettype wire

// [ppd_proc_model.sv]
// processor i/o bus model issuing programmed transfers
`timescale 1ns/1ps
`default_nettype none

module ppd_proc_model (
  input wire logic clk_in,
  input wire ppd_pkg::ppd_bus_drive_t data_drive_in,
  input wire logic bus_dir_ctl_zero_n_in,
  input wire logic bus_dir_ctl_one_n_in,
  input wire logic skip_req_in,
  output logic [0:8] instruction_bits_out,
  output logic io_pause_out,
  output logic timing_pulse_three_out,
  output ppd_pkg::ppd_word_t data_out
);
  ppd_pkg::ppd_word_t ac;
  // wired bus: the device can only pull lines low
  assign data_out = ac & (data_drive_in.data | data_drive_in.oe_n);
  initial begin
    instruction_bits_out = 9'h000;
    io_pause_out = 1'b0;
    timing_pulse_three_out = 1'b0;
    ac = 12'h5a5;
  end
  // pause and code first, pulse three a cycle later, all held to the strobe edge
  task automatic iot(input logic [5:0] dev, input logic [2:0] op, input ppd_pkg::ppd_word_t word,
                     output ppd_pkg::ppd_word_t seen, output logic [2:0] ctl);
    @(posedge clk_in);
    io_pause_out <= 1'b1;
    instruction_bits_out <= {dev, op};
    ac <= word;
    @(posedge clk_in);
    timing_pulse_three_out <= 1'b1;
    @(negedge clk_in);
    seen = data_out;
    ctl = {bus_dir_ctl_zero_n_in, bus_dir_ctl_one_n_in, skip_req_in};
    @(posedge clk_in);
    io_pause_out <= 1'b0;
    timing_pulse_three_out <= 1'b0;
    ac <= ~word; // a released bus does not keep its last value
  endtask : iot
endmodule : ppd_proc_model

`default_nettype wire

// [ppd_control_test.sv]
// self-checking bench for the point-plot display control
`timescale 1ns/1ps
`default_nettype none

module ppd_control_test;
  localparam int STORE_CYC = 50;
  logic clk_in, rst_n_in, system_init_in, console_clear_in, pol_sw, delay_sw, jumper;
  logic [0:8] ibits;
  logic pause, tp3, dir0_n, dir1_n, skip, irq, intens;
  ppd_pkg::ppd_word_t data, seen;
  ppd_pkg::ppd_bus_drive_t drive;
  logic [9:0] x_axis, y_axis;
  ppd_pkg::ppd_mode_t mode;
  logic [2:0] ctl;
  int failures, compares, cycles;

  ppd_control #(.SETTLE_STORAGE_CYCLES(STORE_CYC)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .instruction_bits_in(ibits), .io_pause_in(pause), .timing_pulse_three_in(tp3),
    .system_init_in(system_init_in), .console_clear_in(console_clear_in), .data_in(data),
    .pulse_polarity_switch_in(pol_sw), .delay_length_switch_in(delay_sw), .storage_jumper_in(jumper),
    .data_drive_out(drive), .bus_dir_ctl_zero_n_out(dir0_n), .bus_dir_ctl_one_n_out(dir1_n),
    .skip_req_out(skip), .interrupt_req_out(irq), .intensify_out(intens), .x_axis_out(x_axis),
    .y_axis_out(y_axis), .mode_out(mode));
  ppd_proc_model proc_u (.clk_in(clk_in), .data_drive_in(drive), .bus_dir_ctl_zero_n_in(dir0_n),
    .bus_dir_ctl_one_n_in(dir1_n), .skip_req_in(skip), .instruction_bits_out(ibits),
    .io_pause_out(pause), .timing_pulse_three_out(tp3), .data_out(data));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // hang guard, well above the longest sequence
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic set_sw(input logic d, input logic j, input logic p);
    @(posedge clk_in);
    delay_sw <= d;
    jumper <= j;
    pol_sw <= p;
    repeat (4) @(posedge clk_in);
  endtask : set_sw

  task automatic op(input logic [2:0] code, input ppd_pkg::ppd_word_t w);
    proc_u.iot(ppd_pkg::DEV_CODE, code, w, seen, ctl);
  endtask : op

  // first look one cycle after the strobe, then count to done
  task automatic wait_irq(input int exp_n);
    int n;
    n = 1;
    @(negedge clk_in);
    check("irq_cleared", {11'h0, irq}, 12'h000);
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    check("settle_cycles", n[11:0], exp_n[11:0] + 12'h002);
  endtask : wait_irq

  task automatic settle_case(input logic d, input logic j, input ppd_pkg::ppd_word_t en, input logic [2:0] code,
                             input logic [9:0] v, input int exp_n);
    set_sw(d, j, 1'b0);
    op(ppd_pkg::OPC_LOAD_ENABLE, en);
    check("dir_enable", {10'h0, ctl[2:1]}, 12'h001);
    op(code, {2'b11, v});
    check("dir_load", {10'h0, ctl[2:1]}, 12'h003);
    wait_irq(exp_n);
    check("axis", {2'b00, (code == ppd_pkg::OPC_LOAD_X) ? x_axis : y_axis}, {2'b00, v});
  endtask : settle_case

  task automatic status_case();
    op(ppd_pkg::OPC_READ_ENABLE, 12'hfff);
    check("read_word", seen, 12'h7ff);
    check("dir_read", {10'h0, ctl[2:1]}, 12'h000);
    op(ppd_pkg::OPC_SKIP_DONE, 12'h000);
    check("skip_done", {11'h0, ctl[0]}, 12'h001);
    op(ppd_pkg::OPC_LOAD_ENABLE, 12'h03c);
    op(ppd_pkg::OPC_READ_ENABLE, 12'hfff);
    check("read_chan2", seen, 12'h7fc);
    check("irq_masked", {11'h0, irq}, 12'h000);
    op(ppd_pkg::OPC_CLEAR_DONE, 12'h000);
    op(ppd_pkg::OPC_READ_ENABLE, 12'hfff);
    check("read_cleared", seen, 12'hffc);
    op(ppd_pkg::OPC_SKIP_DONE, 12'h000);
    check("no_skip", {11'h0, ctl[0]}, 12'h000);
  endtask : status_case

  task automatic clear_case();
    op(ppd_pkg::OPC_LOAD_ENABLE, 12'h03f);
    op(ppd_pkg::OPC_LOAD_X, 12'h123);
    wait_irq(ppd_pkg::SETTLE_FAST_CYC);
    @(posedge clk_in) system_init_in <= 1'b1;
    @(posedge clk_in) system_init_in <= 1'b0;
    @(negedge clk_in) check("init_clear", {11'h0, irq}, 12'h000);
    op(ppd_pkg::OPC_LOAD_X, 12'h123);
    wait_irq(ppd_pkg::SETTLE_FAST_CYC);
    @(posedge clk_in) console_clear_in <= 1'b1;
    @(posedge clk_in) console_clear_in <= 1'b0;
    @(negedge clk_in) check("console_clear", {10'h0, irq, mode.int_enable}, 12'h000);
    op(ppd_pkg::OPC_LOAD_ENABLE, 12'h03f);
    op(ppd_pkg::OPC_LOAD_X, 12'h123);
    wait_irq(ppd_pkg::SETTLE_FAST_CYC);
    op(ppd_pkg::OPC_LOAD_ENABLE, 12'h03b);
    @(negedge clk_in) check("colour_clear", {11'h0, irq}, 12'h000);
    op(ppd_pkg::OPC_LOAD_X, 12'h123);
    wait_irq(ppd_pkg::SETTLE_FAST_CYC);
    op(ppd_pkg::OPC_LOAD_ENABLE, 12'h033);
    @(negedge clk_in) check("erase_clear", {11'h0, irq}, 12'h000);
    check("mode_bits", {6'h0, mode}, 12'h02c);
    proc_u.iot(6'h06, ppd_pkg::OPC_LOAD_X, 12'habc, seen, ctl);
    @(negedge clk_in) check("other_device", {2'b00, x_axis}, 12'h123);
  endtask : clear_case

  task automatic pulse_case(input ppd_pkg::ppd_word_t en, input logic lvl, input int exp_n);
    int n;
    n = 0;
    op(ppd_pkg::OPC_LOAD_ENABLE, en);
    check("idle_level", {11'h0, intens}, {11'h0, ~lvl});
    op(ppd_pkg::OPC_INTENSIFY, 12'h000);
    @(negedge clk_in);
    while (intens === lvl && n < 2000) begin
      n++;
      @(negedge clk_in);
    end
    check("pulse_width", n[11:0], exp_n[11:0]);
  endtask : pulse_case

  initial begin
    rst_n_in = 1'b0;
    system_init_in = 1'b0;
    console_clear_in = 1'b0;
    pol_sw = 1'b0;
    delay_sw = 1'b1;
    jumper = 1'b0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    settle_case(1'b1, 1'b0, 12'h03f, ppd_pkg::OPC_LOAD_X, 10'h201, ppd_pkg::SETTLE_RASTER_CYC);
    settle_case(1'b1, 1'b0, 12'h03b, ppd_pkg::OPC_LOAD_Y, 10'h1fe, ppd_pkg::SETTLE_RASTER_RED_CYC);
    settle_case(1'b1, 1'b1, 12'h03f, ppd_pkg::OPC_LOAD_X, 10'h3ff, STORE_CYC);
    settle_case(1'b0, 1'b0, 12'h03f, ppd_pkg::OPC_LOAD_Y, 10'h155, ppd_pkg::SETTLE_FAST_CYC);
    status_case();
    clear_case();
    pulse_case(12'h03f, 1'b1, ppd_pkg::INTENS_GREEN_CYC);
    pulse_case(12'h03b, 1'b1, ppd_pkg::INTENS_RED_CYC);
    pulse_case(12'h02b, 1'b1, ppd_pkg::INTENS_GREEN_CYC);
    set_sw(1'b0, 1'b0, 1'b1);
    pulse_case(12'h03b, 1'b0, ppd_pkg::INTENS_RED_CYC);
    close_out();
  end
endmodule : ppd_control_test

`default_nettype wire
